// ===== ads_pkg.sv
package ads_pkg;

  // ****************************************
  // Register select codes
  // ****************************************
  localparam logic [1:0] ADS_RS_STATUS = 2'h0;
  localparam logic [1:0] ADS_RS_MODE = 2'h1;
  localparam logic [1:0] ADS_RS_FILTER = 2'h2;
  localparam logic [1:0] ADS_RS_DATA = 2'h3;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0] ADS_STATUS_RST = 8'h88;
  localparam logic [7:0] ADS_MODE_RST = 8'h02;
  localparam logic [7:0] ADS_MODE_WMASK = 8'hfa;
  localparam logic [1:0] ADS_CHAN_RST = 2'h0;

  // ****************************************
  // Conversion mode codes
  // ****************************************
  localparam logic [1:0] ADS_MD_CONT = 2'h0;
  localparam logic [1:0] ADS_MD_SINGLE = 2'h2;
  localparam logic [1:0] ADS_MD_DOWN = 2'h3;

  // ****************************************
  // Channel codes
  // ****************************************
  localparam logic [1:0] ADS_CH_DIFF = 2'h0;
  localparam logic [1:0] ADS_CH_RSVD = 2'h1;
  localparam logic [1:0] ADS_CH_SHORT = 2'h2;
  localparam logic [1:0] ADS_CH_SUPPLY = 2'h3;

  // ****************************************
  // Serial frame lengths and timing
  // ****************************************
  localparam logic [4:0] ADS_LEN_BYTE = 5'h08;
  localparam logic [4:0] ADS_LEN_WORD = 5'h10;
  localparam int ADS_CLK_HZ = 10_000_000;
  localparam int ADS_PERIOD_CYC = 1_000_000;
  localparam int ADS_LEAD_CYC = 100;
  localparam int ADS_FIRST_PERIODS = 2;

  // ****************************************
  // Register layouts
  // ****************************************
  typedef struct packed {
    logic rdy_n;
    logic err;
    logic [1:0] zero_hi;
    logic one;
    logic part_variant_flag;
    logic [1:0] channel_select;
  } ads_status_t;

  typedef struct packed {
    logic [1:0] conversion_mode_field;
    logic [1:0] input_range_field;
    logic burnout_current_enable;
    logic zero_b2;
    logic buffer_enable;
    logic zero_b0;
  } ads_mode_t;

  typedef struct packed {
    logic wen_n;
    logic zero_b6;
    logic [1:0] register_select;
    logic read;
    logic cont_read;
    logic [1:0] channel_select;
  } ads_comm_t;

endpackage

// ===== ads_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module ads_pin_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Raw pins
  input wire logic [WIDTH-1:0] pin_raw,
  // Synchronised levels and edges
  output logic [WIDTH-1:0] pin_sync,
  output logic [WIDTH-1:0] pin_rise,
  output logic [WIDTH-1:0] pin_fall
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // ****************************************
  // Two-stage synchroniser and edge finder
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end
    else if (ce)
    begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign pin_sync = sync_q;
  assign pin_rise = sync_q & ~prev_q;
  assign pin_fall = ~sync_q & prev_q;

endmodule

`default_nettype wire

// ===== ads_status_mode.sv
// Overview of operation
// (R1) Status register is eight bits, read only; writes never change it.
// (R2) Host reads status by commanding a read with register select zero.
// (R3) Status byte shifts out most significant bit first.
// (R4) Ready flag goes low when a new result is loaded.
// (R5) Ready returns high after data read and shortly before each update.
// (R6) Ready is forced high when power-down mode is selected.
// (R7) Serial output pin mirrors ready while no read is in progress.
// (R8) Clamp bit updates with ready, set when result was clamped.
// (R9) Clamp bit clears on a host write that starts a conversion.
// (R10) Status bits five and four read zero, bit three reads one.
// (R11) Status bit two carries a fixed part variant indicator.
// (R12) Status bits one and zero show the channel being converted.
// (R13) Mode register is eight bits, read and write, resets to 02.
// (R14) Mode register shifts most significant bit first both ways.
// (R15) Mode write resets modulator and filter and sets ready.
// (R16) Mode fields: mode, range, burnout, zero, buffer, zero.
// (R17) Single mode converts once after two periods, then powers down.
// (R18) Select 00 reads status, select 01 reaches the mode register.
// (R19) Channel codes: differential, reserved, short, supply monitor.
// (R20) Host always writes zero into mode bit two.
// (R21) Mode read returns last value with fixed bits as zero.
`timescale 1ns/1ns
`default_nettype none

module ads_status_mode
  import ads_pkg::*;
#(
  parameter int PERIOD_CYC = ads_pkg::ADS_PERIOD_CYC,
  parameter int LEAD_CYC = ads_pkg::ADS_LEAD_CYC,
  // Arbitrary value
  parameter logic VARIANT = 1'b1
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_rdy,
  output logic dout_oe,
  // Converter core
  input wire logic [15:0] result_word,
  input wire logic result_clamped,
  output ads_pkg::ads_mode_t mode_cfg,
  output logic [1:0] channel_select,
  output logic mod_filter_reset,
  output logic core_power_down,
  output logic result_load
);

  import ads_pkg::*;

  localparam int CW = $clog2(ADS_FIRST_PERIODS * PERIOD_CYC + 1);
  localparam logic [CW-1:0] PER = CW'(PERIOD_CYC);
  localparam logic [CW-1:0] FIRST = CW'(ADS_FIRST_PERIODS * PERIOD_CYC);
  localparam logic [CW-1:0] LEAD = CW'(LEAD_CYC);

  typedef enum {SER_CMD, SER_WRITE, SER_READ} ads_ser_t;
  typedef enum {CV_DOWN, CV_RUN} ads_conv_t;

  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic [2:0] pin_sync;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  ads_pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin_raw({sclk, cs_n, din}),
    .pin_sync(pin_sync),
    .pin_rise(pin_rise),
    .pin_fall(pin_fall)
  );

  wire sclk_rise = pin_rise[2];
  wire sclk_fall = pin_fall[2];
  wire cs_idle = pin_sync[1];
  wire din_s = pin_sync[0];

  // ****************************************
  // State
  // ****************************************
  ads_ser_t ser_q;
  ads_ser_t ser_d;
  ads_conv_t conv_q;
  ads_conv_t conv_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [4:0] len_q;
  logic [4:0] len_d;
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic [1:0] rs_q;
  logic [1:0] rs_d;
  logic dout_q;
  logic dout_d;
  ads_mode_t mode_q;
  logic [1:0] chan_q;
  logic rdy_n_q;
  logic err_q;
  logic [15:0] data_q;
  logic [CW-1:0] tmr_q;
  logic first_q;
  logic reset_pulse_q;
  logic load_pulse_q;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [4:0] read_len(input logic [1:0] rs);
    read_len = (rs == ADS_RS_DATA) ? ADS_LEN_WORD : ADS_LEN_BYTE;
  endfunction

  function automatic logic [15:0] left_align(input logic [7:0] b);
    left_align = {b, 8'h00};
  endfunction

  // ****************************************
  // Status image
  // ****************************************
  ads_status_t status_img;
  // (R10) Fixed status bits
  assign status_img.zero_hi = 2'h0;
  assign status_img.one = 1'b1;
  // (R11) Variant indicator
  assign status_img.part_variant_flag = VARIANT;
  // (R12) Active channel
  assign status_img.channel_select = chan_q;
  assign status_img.rdy_n = rdy_n_q;
  assign status_img.err = err_q;

  // ****************************************
  // Serial decoding
  // ****************************************
  wire [7:0] in_byte = {shift_q[6:0], din_s};
  ads_comm_t comm;
  assign comm = in_byte;
  wire byte_done = sclk_rise && (cnt_q == ADS_LEN_BYTE - 5'h01);
  wire cmd_start = (ser_q == SER_CMD) && sclk_rise &&
                   !(cnt_q == 5'h00 && din_s);
  wire cmd_done = (ser_q == SER_CMD) && byte_done && !cs_idle;
  wire chan_write = cmd_done && !comm.read && comm.channel_select != chan_q;
  wire mode_write = (ser_q == SER_WRITE) && byte_done && !cs_idle &&
                    rs_q == ADS_RS_MODE;
  wire read_last = (ser_q == SER_READ) && sclk_rise && !cs_idle &&
                   (cnt_q == len_q - 5'h01);
  wire data_read = read_last && rs_q == ADS_RS_DATA;
  // (R18) Register selection for reads
  wire [7:0] read_byte = (comm.register_select == ADS_RS_MODE) ?
                         (mode_q & ADS_MODE_WMASK) : status_img;
  wire [15:0] read_word = (comm.register_select == ADS_RS_DATA) ?
                          data_q : left_align(read_byte);

  // ****************************************
  // Serial engine next state
  // ****************************************
  always_comb
  begin
    ser_d = ser_q;
    cnt_d = cnt_q;
    len_d = len_q;
    shift_d = shift_q;
    rs_d = rs_q;
    // (R7) Ready mirrored on output pin
    dout_d = (ser_q == SER_READ) ? dout_q : rdy_n_q;
    if (cs_idle)
    begin
      ser_d = SER_CMD;
      cnt_d = 5'h00;
    end
    else
    begin
      case (ser_q)
        SER_CMD:
        begin
          if (cmd_start)
          begin
            shift_d = {shift_q[14:0], din_s};
            cnt_d = cnt_q + 5'h01;
          end
          if (cmd_done)
          begin
            cnt_d = 5'h00;
            rs_d = comm.register_select;
            // (R2) Read command, any register select
            if (comm.read)
            begin
              ser_d = SER_READ;
              len_d = read_len(comm.register_select);
              shift_d = read_word;
              // (R3) Most significant bit first
              dout_d = read_word[15];
            end
            else if (comm.register_select != ADS_RS_STATUS)
            begin
              ser_d = SER_WRITE;
            end
            else
            begin
              ser_d = SER_CMD;
            end
          end
        end
        SER_WRITE:
        begin
          if (sclk_rise)
          begin
            // (R14) Shift in top bit first
            shift_d = {shift_q[14:0], din_s};
            cnt_d = cnt_q + 5'h01;
          end
          if (byte_done)
          begin
            ser_d = SER_CMD;
            cnt_d = 5'h00;
          end
        end
        SER_READ:
        begin
          if (sclk_rise)
          begin
            cnt_d = cnt_q + 5'h01;
          end
          if (sclk_fall)
          begin
            shift_d = {shift_q[14:0], 1'b0};
            dout_d = shift_q[15];
          end
          if (read_last)
          begin
            ser_d = SER_CMD;
            cnt_d = 5'h00;
          end
        end
        default:
        begin
          ser_d = SER_CMD;
          cnt_d = 5'h00;
        end
      endcase
    end
  end

  // ****************************************
  // Serial engine registers
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ser_q <= SER_CMD;
      cnt_q <= 5'h00;
      len_q <= ADS_LEN_BYTE;
      shift_q <= 16'h0000;
      rs_q <= ADS_RS_STATUS;
      dout_q <= 1'b1;
    end
    else if (ce)
    begin
      ser_q <= ser_d;
      cnt_q <= cnt_d;
      len_q <= len_d;
      shift_q <= shift_d;
      rs_q <= rs_d;
      dout_q <= dout_d;
    end
  end

  // ****************************************
  // Mode and channel registers
  // ****************************************
  // (R1) Status never written by host
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      // (R13) Mode reset value
      mode_q <= ADS_MODE_RST;
      chan_q <= ADS_CHAN_RST;
    end
    else if (ce)
    begin
      // (R16) Field layout, (R20) bit two held zero, (R21) fixed bits
      if (mode_write)
        mode_q <= in_byte & ADS_MODE_WMASK;
      // (R19) Channel code stored as given
      if (cmd_done && !comm.read)
        chan_q <= comm.channel_select;
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  wire restart = mode_write || chan_write;
  wire [1:0] md_now = mode_q.conversion_mode_field;
  wire [CW-1:0] target = first_q ? FIRST : PER;
  wire tmr_end = (conv_q == CV_RUN) && (tmr_q == target - CW'(1));
  wire pre_update = (conv_q == CV_RUN) && (tmr_q == target - LEAD);
  wire enter_down = (conv_q == CV_RUN) && md_now == ADS_MD_DOWN;
  wire load_now = tmr_end && !restart;

  always_comb
  begin
    conv_d = conv_q;
    case (conv_q)
      CV_DOWN:
      begin
        if (restart)
          conv_d = CV_RUN;
      end
      CV_RUN:
      begin
        // (R17) Single conversion then power down
        if (enter_down)
          conv_d = CV_DOWN;
        else if (load_now && md_now == ADS_MD_SINGLE)
          conv_d = CV_DOWN;
      end
      default:
        conv_d = CV_DOWN;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      conv_q <= CV_RUN;
      tmr_q <= '0;
      first_q <= 1'b1;
    end
    else if (ce)
    begin
      conv_q <= conv_d;
      // (R17) First result after two periods
      if (restart || conv_q == CV_DOWN)
      begin
        tmr_q <= '0;
        first_q <= 1'b1;
      end
      else if (tmr_end)
      begin
        tmr_q <= '0;
        first_q <= 1'b0;
      end
      else
        tmr_q <= tmr_q + CW'(1);
    end
  end

  // ****************************************
  // Ready, clamp and result registers
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rdy_n_q <= ADS_STATUS_RST[7];
      err_q <= ADS_STATUS_RST[6];
      data_q <= 16'h0000;
      load_pulse_q <= 1'b0;
      reset_pulse_q <= 1'b0;
    end
    else if (ce)
    begin
      load_pulse_q <= load_now;
      reset_pulse_q <= restart;
      if (load_now)
      begin
        // (R4) New result clears ready
        rdy_n_q <= 1'b0;
        // (R8) Clamp flag with ready
        err_q <= result_clamped;
        data_q <= result_word;
      end
      else
      begin
        // (R5) Set on data read and before update
        // (R6) Set on entering power-down mode
        // (R15) Set on mode write
        if (data_read || pre_update || enter_down || mode_write)
          rdy_n_q <= 1'b1;
        // (R9) Conversion start clears clamp
        if (restart)
          err_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dout_rdy = dout_q;
  assign dout_oe = !cs_idle;
  assign mode_cfg = mode_q;
  assign channel_select = chan_q;
  // (R15) Modulator and filter reset
  assign mod_filter_reset = reset_pulse_q;
  assign core_power_down = (conv_q == CV_DOWN);
  assign result_load = load_pulse_q;

endmodule

`default_nettype wire

// ===== ads_status_mode_checker.sv
`timescale 1ns/1ns
`default_nettype none

module ads_status_mode_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pins
  input wire logic cs_n,
  input wire logic dout_rdy,
  input wire logic dout_oe,
  // Core side
  input wire ads_pkg::ads_mode_t mode_cfg,
  input wire logic mod_filter_reset,
  input wire logic core_power_down,
  input wire logic result_load
);
  import ads_pkg::*;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_mode_rst_val: assert property (
    $rose(rst_n) |-> mode_cfg == ADS_MODE_RST)
    else $error("mode reset value wrong");
  a_fixed_zero: assert property (
    mode_cfg.zero_b2 == 1'b0 && mode_cfg.zero_b0 == 1'b0)
    else $error("mode fixed bits not zero");
  a_write_restart: assert property (
    $changed(mode_cfg) |-> ##[0:2] mod_filter_reset)
    else $error("no restart after mode write");
  a_write_ready: assert property (
    $changed(mode_cfg) |-> ##[1:12] (!dout_oe && dout_rdy))
    else $error("ready not set after mode write");
  a_load_pulse: assert property (
    result_load |=> !result_load)
    else $error("load pulse too long");
  a_load_ready: assert property (
    result_load && !dout_oe |-> ##[0:2] !dout_rdy)
    else $error("ready pin not low on load");
  a_oe_follow: assert property (
    $fell(cs_n) |-> ##[1:4] dout_oe)
    else $error("output not enabled");
  a_single_down: assert property (
    result_load && mode_cfg.conversion_mode_field == ADS_MD_SINGLE
    |-> ##[0:3] core_power_down)
    else $error("single mode did not power down");
  a_down_ready: assert property (
    $rose(core_power_down) && mode_cfg.conversion_mode_field == ADS_MD_DOWN
    |-> ##[0:12] (!dout_oe && dout_rdy))
    else $error("ready not set on power down");
  a_down_noload: assert property (
    core_power_down && mode_cfg.conversion_mode_field == ADS_MD_DOWN
    |-> !result_load)
    else $error("load while powered down");
endmodule

bind ads_status_mode ads_status_mode_checker u_chk (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .cs_n(cs_n),
  .dout_rdy(dout_rdy),
  .dout_oe(dout_oe),
  .mode_cfg(mode_cfg),
  .mod_filter_reset(mod_filter_reset),
  .core_power_down(core_power_down),
  .result_load(result_load)
);

`default_nettype wire

// ===== ads_host.sv
`timescale 1ns/1ns
`default_nettype none

module ads_host (
  // Clock
  input wire logic ref_clk,
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout_rdy,
  // Read result
  output logic done,
  output logic [15:0] rd
);
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
    done = 1'b0;
    rd = 16'h0000;
  end

  // One link clock: drive on fall, sample on rise
  task automatic bitx(input logic b);
    sclk <= 1'b0;
    din <= b;
    repeat (4) @(posedge ref_clk);
    sclk <= 1'b1;
    rd <= {rd[14:0], dout_rdy};
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                      input int nw, input int nr);
    cs_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 7; i >= 0; i--)
      bitx(cmd[i]);
    for (int i = nw - 1; i >= 0; i--)
      bitx(wd[i]);
    rd <= 16'h0000;
    for (int i = 0; i < nr; i++)
      bitx(1'b0);
    done <= (nr > 0);
    cs_n <= 1'b1;
    din <= ~din;
    @(posedge ref_clk);
    done <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule

`default_nettype wire

// ===== ads_status_mode_bench.sv
`timescale 1ns/1ns
`default_nettype none

module ads_status_mode_bench;
  import ads_pkg::*;

  localparam int PER = 600;
  // Arbitrary variant value
  localparam logic VAR = 1'b0;

  logic ref_clk;
  logic rst_n;
  logic ce;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout_rdy;
  logic dout_oe;
  logic [15:0] result_word;
  logic result_clamped;
  ads_mode_t mode_cfg;
  logic mod_filter_reset;
  logic core_power_down;
  logic result_load;
  logic done;
  logic [15:0] rd;
  logic [1:0] ch;
  logic [1:0] chan;
  logic [7:0] v;
  logic [31:0] seed;
  logic [15:0] exp_q[$];
  int err_total;
  int checked;
  int cyc;

  ads_status_mode #(.PERIOD_CYC(PER), .LEAD_CYC(10), .VARIANT(VAR))
  u_ads_status_mode (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout_rdy(dout_rdy), .dout_oe(dout_oe),
    .result_word(result_word), .result_clamped(result_clamped),
    .mode_cfg(mode_cfg), .channel_select(chan),
    .mod_filter_reset(mod_filter_reset),
    .core_power_down(core_power_down), .result_load(result_load)
  );

  ads_host u_ads_host (
    .ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout_rdy(dout_rdy), .done(done), .rd(rd)
  );

  always #50 ref_clk = ~ref_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic test_done();
    if (err_total == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want)
    begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, seen, want);
    end
  endtask

  task automatic rd_reg(input logic [1:0] sel, input int n,
                        input logic [15:0] want);
    exp_q.push_back(want);
    u_ads_host.xfer({2'b00, sel, 1'b1, 1'b0, ch}, 8'h00, 0, n);
  endtask

  task automatic stat(input logic rdy, input logic err);
    rd_reg(ADS_RS_STATUS, 8, {8'h00, rdy, err, 3'b001, VAR, ch});
  endtask

  task automatic wr_mode(input logic [7:0] m);
    u_ads_host.xfer({2'b00, ADS_RS_MODE, 2'b00, ch}, m & 8'hfb, 8, 0);
  endtask

  task automatic wait_load(input int lim);
    int i;
    i = 0;
    @(negedge ref_clk);
    while (result_load !== 1'b1 && i < lim)
    begin
      @(negedge ref_clk);
      i++;
    end
  endtask

  // ****************************************
  // Result monitor
  // ****************************************
  always @(posedge ref_clk)
  begin
    cyc++;
    if (done === 1'b1)
      check(rd, exp_q.pop_front());
    if (cyc == 30000)
    begin
      err_total++;
      test_done();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    result_word = 16'h0000;
    result_clamped = 1'b0;
    seed = 32'd52;
    ch = ADS_CH_DIFF;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd_reg(ADS_RS_MODE, 8, 16'h0002);
    stat(1'b1, 1'b0);
    wr_mode(8'hc2);
    check(core_power_down, 1'b1);
    u_ads_host.xfer(8'h00, 8'hff, 8, 0);
    stat(1'b1, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      v = {2'(i), seed[5:0]} & 8'hfb;
      wr_mode(v);
      check(mode_cfg, v & ADS_MODE_WMASK);
      rd_reg(ADS_RS_MODE, 8, {8'h00, v & ADS_MODE_WMASK});
    end
    for (int c = 0; c < 4; c++)
    begin
      ch = 2'(3 - c);
      u_ads_host.xfer({2'b00, ADS_RS_STATUS, 2'b00, ch}, 8'h00, 0, 0);
      check(chan, ch);
      stat(1'b1, 1'b0);
    end
    seed = xs(seed);
    result_word <= seed[15:0];
    result_clamped <= 1'b1;
    wr_mode(8'h02);
    wait_load(1400);
    check(result_load, 1'b1);
    repeat (3) @(negedge ref_clk);
    check(dout_rdy, 1'b0);
    @(posedge ref_clk);
    result_clamped <= 1'b0;
    stat(1'b0, 1'b1);
    rd_reg(ADS_RS_DATA, 16, result_word);
    stat(1'b1, 1'b1);
    wr_mode(8'h12);
    stat(1'b1, 1'b0);
    wr_mode(8'h82);
    wait_load(1400);
    check(result_load, 1'b1);
    repeat (4) @(negedge ref_clk);
    check(core_power_down, 1'b1);
    check(dout_rdy, 1'b0);
    @(posedge ref_clk);
    stat(1'b0, 1'b0);
    wr_mode(8'hc2);
    @(negedge ref_clk);
    check(dout_rdy, 1'b1);
    test_done();
  end
endmodule

`default_nettype wire
